// file: hw/ifcm_pkg.sv
// shared constants and types for the four-channel serial multiplexer
`default_nettype none
package ifcm_pkg;
    // clocking and serial link rate
    localparam int SYS_CLK_HZ = 10_000_000;
    localparam int LINK_MAX_HZ = 400_000;
    localparam int LINK_HALF_CYC = SYS_CLK_HZ / (2 * LINK_MAX_HZ);
    // settle time after a line bridge lets go, least time rounded up
    localparam int SETTLE_NS = 300;
    localparam int SETTLE_CYC = (SETTLE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [1:0] SETTLE_LOAD = 2'(SETTLE_CYC);
    // channel count, target address and bits per byte
    localparam int NUM_CH = 4;
    localparam logic [3:0] ADDR_HI_DEF = 4'h7;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // control byte layout
    localparam int CTL_SEL_LSB = 0;
    localparam int CTL_EN_BIT = 2;
    localparam int RD_IRQ_LSB = 4;
    localparam logic [2:0] CTL_RESET = 3'h0;
    // serial target states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
    } ifcm_state_t;
    // line bridge direction states
    typedef enum logic [1:0] {
        LN_IDLE, LN_UP_LOW, LN_DN_LOW, LN_SETTLE
    } ifcm_line_t;
endpackage : ifcm_pkg
`default_nettype wire

// file: hw/ifcm_line_if.sv
// carrier between the multiplexer top and one line bridge
`default_nettype none
interface ifcm_line_if;
    logic up_lvl;
    logic dn_lvl;
    logic own_pull;
    logic drive_up;
    logic drive_dn;
    modport bridge (input up_lvl, input dn_lvl, input own_pull, output drive_up, output drive_dn);
    modport top (output up_lvl, output dn_lvl, output own_pull, input drive_up, input drive_dn);
endinterface : ifcm_line_if
`default_nettype wire

// file: hw/ifcm_line_bridge.sv
// open-drain line bridge that forwards a low level in one direction at a time
`default_nettype none
module ifcm_line_bridge (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // line levels and drives
    ifcm_line_if.bridge ln
);
    ifcm_pkg::ifcm_line_t state;
    ifcm_pkg::ifcm_line_t next_state;
    logic [1:0] cnt;
    logic [1:0] next_cnt;

    // direction lock: whoever pulls first owns the line until it lets go
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        unique case (state)
            ifcm_pkg::LN_IDLE: begin
                if (ln.own_pull) begin
                    next_state = ifcm_pkg::LN_SETTLE;
                    next_cnt = ifcm_pkg::SETTLE_LOAD;
                end else if (!ln.up_lvl) begin
                    next_state = ifcm_pkg::LN_UP_LOW;
                end else if (!ln.dn_lvl) begin
                    next_state = ifcm_pkg::LN_DN_LOW;
                end
            end
            ifcm_pkg::LN_UP_LOW: begin
                if (ln.up_lvl) begin
                    next_state = ifcm_pkg::LN_SETTLE;
                    next_cnt = ifcm_pkg::SETTLE_LOAD;
                end
            end
            ifcm_pkg::LN_DN_LOW: begin
                if (ln.dn_lvl) begin
                    next_state = ifcm_pkg::LN_SETTLE;
                    next_cnt = ifcm_pkg::SETTLE_LOAD;
                end
            end
            ifcm_pkg::LN_SETTLE: begin
                // ignore our own echo while it drains through the synchronisers
                if (ln.own_pull) begin
                    next_cnt = ifcm_pkg::SETTLE_LOAD;
                end else if (cnt == 2'h1) begin
                    next_state = ifcm_pkg::LN_IDLE;
                end else begin
                    next_cnt = cnt - 2'h1;
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= ifcm_pkg::LN_IDLE;
            cnt <= 2'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // drives follow the owner
    assign ln.drive_dn = (state == ifcm_pkg::LN_UP_LOW);
    assign ln.drive_up = (state == ifcm_pkg::LN_DN_LOW);
endmodule : ifcm_line_bridge
`default_nettype wire

// file: hw/ifcm_mux_top.sv
// four-channel serial bus multiplexer with interrupt combining
`default_nettype none
module ifcm_mux_top #(
    parameter logic [3:0] ADDR_HI = ifcm_pkg::ADDR_HI_DEF
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // upstream clock line, also the link clock
    input wire logic up_clk,
    output logic up_clk_out,
    output logic up_clk_oe,
    // upstream data line
    input wire logic up_dat_in,
    output logic up_dat_out,
    output logic up_dat_oe,
    // downstream clock lines
    input wire logic [3:0] down_clk_ch_in,
    output logic [3:0] down_clk_ch_out,
    output logic [3:0] down_clk_ch_oe,
    // downstream data lines
    input wire logic [3:0] down_dat_ch_in,
    output logic [3:0] down_dat_ch_out,
    output logic [3:0] down_dat_ch_oe,
    // interrupts and straps
    input wire logic [3:0] chan_irq_in_n,
    output logic irq_out_n,
    input wire logic [2:0] addr_strap
);
    // link domain: data bit captured on each rising upstream clock edge
    logic link_bit;
    always_ff @(posedge up_clk) begin
        link_bit <= up_dat_in;
    end

    // two-flop synchronisers for every pin read by the system domain
    localparam int SW = 17;
    logic [SW-1:0] raw;
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [1:0] sync3;
    assign raw = {addr_strap, chan_irq_in_n, down_dat_ch_in, down_clk_ch_in, up_dat_in, up_clk};
    // first two stages run through reset so the straps arrive before capture
    always_ff @(posedge sys_clk) begin
        sync1 <= raw;
        sync2 <= sync1;
        if (rst) begin
            sync3 <= 2'h3;
        end else begin
            sync3 <= sync2[1:0];
        end
    end

    logic scl_s;
    logic sda_s;
    logic [3:0] dn_clk_s;
    logic [3:0] dn_dat_s;
    logic [3:0] irq_s;
    logic [2:0] strap_s;
    assign scl_s = sync2[0];
    assign sda_s = sync2[1];
    assign dn_clk_s = sync2[5:2];
    assign dn_dat_s = sync2[9:6];
    assign irq_s = sync2[13:10];
    assign strap_s = sync2[16:14];

    // bus events seen at the system clock, well inside a half link period
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_rise = scl_s & ~sync3[0];
    assign scl_fall = ~scl_s & sync3[0];
    assign start_ev = scl_s & sync3[0] & sync3[1] & ~sda_s;
    assign stop_ev = scl_s & sync3[0] & ~sync3[1] & sda_s;

    // serial target state
    ifcm_pkg::ifcm_state_t state;
    ifcm_pkg::ifcm_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] rd_sh;
    logic [7:0] next_rd_sh;
    logic rw;
    logic next_rw;
    logic mack;
    logic next_mack;
    logic own_pull;
    logic next_own_pull;
    logic [2:0] ctl;
    logic [2:0] next_ctl;
    logic [2:0] strap_q;
    logic [2:0] next_strap_q;
    logic irq_q;
    logic next_irq_q;
    logic [3:0] irq_lvl;
    logic [3:0] next_irq_lvl;
    logic [7:0] rd_val;
    logic addr_hit;

    // read byte: pending interrupts high, one spare zero, then control bits
    assign rd_val = {~irq_lvl, 1'b0, ctl};
    assign addr_hit = (shreg[7:1] == {ADDR_HI, strap_q});

    // byte engine: address, write, read and acknowledge phases
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shreg = shreg;
        next_rd_sh = rd_sh;
        next_rw = rw;
        next_mack = mack;
        next_own_pull = own_pull;
        next_ctl = ctl;
        next_strap_q = strap_q;
        next_irq_lvl = irq_s;
        next_irq_q = &irq_s;
        if (start_ev) begin
            next_state = ifcm_pkg::ST_ADDR;
            next_cnt = 4'h0;
            next_own_pull = 1'b0;
        end else if (stop_ev) begin
            next_state = ifcm_pkg::ST_IDLE;
            next_own_pull = 1'b0;
        end else begin
            unique case (state)
                ifcm_pkg::ST_IDLE: begin
                    next_own_pull = 1'b0;
                end
                ifcm_pkg::ST_ADDR, ifcm_pkg::ST_WR: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], link_bit};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == ifcm_pkg::BITS_PER_BYTE) begin
                        next_cnt = 4'h0;
                        if (state == ifcm_pkg::ST_WR) begin
                            next_ctl = shreg[2:0];
                            next_own_pull = 1'b1;
                            next_state = ifcm_pkg::ST_WR_ACK;
                        end else if (addr_hit) begin
                            next_rw = shreg[0];
                            next_own_pull = 1'b1;
                            next_state = ifcm_pkg::ST_ADDR_ACK;
                        end else begin
                            next_state = ifcm_pkg::ST_IDLE;
                        end
                    end
                end
                ifcm_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        next_own_pull = 1'b0;
                        next_state = ifcm_pkg::ST_WR;
                    end
                end
                ifcm_pkg::ST_ADDR_ACK, ifcm_pkg::ST_RD_ACK: begin
                    if (scl_rise) begin
                        next_mack = link_bit;
                    end else if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (state == ifcm_pkg::ST_ADDR_ACK && !rw) begin
                            next_own_pull = 1'b0;
                            next_state = ifcm_pkg::ST_WR;
                        end else if (state == ifcm_pkg::ST_ADDR_ACK || !mack) begin
                            next_own_pull = ~rd_val[7];
                            next_rd_sh = {rd_val[6:0], 1'b0};
                            next_state = ifcm_pkg::ST_RD;
                        end else begin
                            next_own_pull = 1'b0;
                            next_state = ifcm_pkg::ST_IDLE;
                        end
                    end
                end
                ifcm_pkg::ST_RD: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt == ifcm_pkg::BITS_PER_BYTE) begin
                            next_own_pull = 1'b0;
                            next_state = ifcm_pkg::ST_RD_ACK;
                        end else begin
                            next_own_pull = ~rd_sh[7];
                            next_rd_sh = {rd_sh[6:0], 1'b0};
                        end
                    end
                end
            endcase
        end
        if (rst) begin
            next_strap_q = strap_s;
        end
    end

    // registers of the byte engine and control
    always_ff @(posedge sys_clk) begin
        strap_q <= next_strap_q;
        if (rst) begin
            state <= ifcm_pkg::ST_IDLE;
            cnt <= 4'h0;
            shreg <= 8'h00;
            rd_sh <= 8'h00;
            rw <= 1'b0;
            mack <= 1'b1;
            own_pull <= 1'b0;
            ctl <= ifcm_pkg::CTL_RESET;
            irq_q <= 1'b1;
            irq_lvl <= 4'hF;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shreg <= next_shreg;
            rd_sh <= next_rd_sh;
            rw <= next_rw;
            mack <= next_mack;
            own_pull <= next_own_pull;
            ctl <= next_ctl;
            irq_q <= next_irq_q;
            irq_lvl <= next_irq_lvl;
        end
    end
    assign irq_out_n = irq_q;

    // selected channel levels fed to the line bridges
    logic sel_en;
    logic [1:0] sel;
    assign sel_en = ctl[ifcm_pkg::CTL_EN_BIT];
    assign sel = ctl[ifcm_pkg::CTL_SEL_LSB +: 2];

    ifcm_line_if ln_clk ();
    ifcm_line_if ln_dat ();
    assign ln_clk.up_lvl = scl_s;
    assign ln_clk.dn_lvl = sel_en ? dn_clk_s[sel] : 1'b1;
    assign ln_clk.own_pull = 1'b0;
    assign ln_dat.up_lvl = sda_s;
    assign ln_dat.dn_lvl = sel_en ? dn_dat_s[sel] : 1'b1;
    assign ln_dat.own_pull = own_pull;

    ifcm_line_bridge u_clk_bridge (
        .sys_clk(sys_clk),
        .rst(rst),
        .ln(ln_clk)
    );
    ifcm_line_bridge u_dat_bridge (
        .sys_clk(sys_clk),
        .rst(rst),
        .ln(ln_dat)
    );

    // upstream drives: own acknowledge and read bits, plus forwarded lows
    assign up_clk_out = 1'b0;
    assign up_dat_out = 1'b0;
    assign up_clk_oe = ln_clk.drive_up;
    assign up_dat_oe = own_pull | ln_dat.drive_up;

    // one decoded channel enable, so at most one pair ever driven
    genvar ch;
    generate
        for (ch = 0; ch < ifcm_pkg::NUM_CH; ch++) begin : g_ch
            logic ch_on;
            assign ch_on = sel_en && (sel == 2'(ch));
            assign down_clk_ch_out[ch] = 1'b0;
            assign down_dat_ch_out[ch] = 1'b0;
            assign down_clk_ch_oe[ch] = ch_on & ln_clk.drive_dn;
            assign down_dat_ch_oe[ch] = ch_on & ln_dat.drive_dn;
        end
    endgenerate
endmodule : ifcm_mux_top
`default_nettype wire

// file: verif/ifcm_mux_monitor.sv
// port checker for the four-channel serial multiplexer
`default_nettype none
module ifcm_mux_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // upstream lines
    input wire logic up_clk,
    input wire logic up_clk_out,
    input wire logic up_dat_in,
    input wire logic up_dat_out,
    input wire logic up_dat_oe,
    // downstream lines
    input wire logic [3:0] down_clk_ch_out,
    input wire logic [3:0] down_clk_ch_oe,
    input wire logic [3:0] down_dat_ch_in,
    input wire logic [3:0] down_dat_ch_out,
    input wire logic [3:0] down_dat_ch_oe,
    // interrupts
    input wire logic [3:0] chan_irq_in_n,
    input wire logic irq_out_n
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // open-drain pins only pull low
    a_drive_low: assert property (!up_clk_out && !up_dat_out && down_clk_ch_out == 4'h0 && down_dat_ch_out == 4'h0)
        else $error("open-drain data value not low");
    // at most one channel pulled
    a_one_clk_ch: assert property ($onehot0(down_clk_ch_oe))
        else $error("several downstream clocks driven");
    a_one_dat_ch: assert property ($onehot0(down_dat_ch_oe))
        else $error("several downstream data lines driven");
    // reset clears the upstream data pull, every downstream pull and the interrupt output
    a_reset_clear: assert property (disable iff (1'b0) rst |=> !up_dat_oe && down_clk_ch_oe == 4'h0
        && down_dat_ch_oe == 4'h0 && irq_out_n) else $error("reset left a line driven");
    // interrupt output is the and of the inputs, three edges late
    a_irq_and: assert property (!$past(rst) && !$past(rst, 2) && !$past(rst, 3)
        |-> irq_out_n == &$past(chan_irq_in_n, 3)) else $error("interrupt output wrong");
    // downstream clock pull needs a recent upstream clock low
    a_dn_clk_cause: assert property (|down_clk_ch_oe |-> !(up_clk && $past(up_clk) && $past(up_clk, 2)
        && $past(up_clk, 3) && $past(up_clk, 4) && $past(up_clk, 5))) else $error("clock pull without cause");
    // downstream data pull needs a recent upstream data low
    a_dn_dat_cause: assert property (|down_dat_ch_oe |-> !(up_dat_in && $past(up_dat_in) && $past(up_dat_in, 2)
        && $past(up_dat_in, 3) && $past(up_dat_in, 4) && $past(up_dat_in, 5))) else $error("data pull without cause");
    // upstream data pull in clock high comes from a downstream low
    a_up_dat_cause: assert property ($rose(up_dat_oe) && up_clk |-> !$past(&down_dat_ch_in, 2))
        else $error("upstream pull without cause");
    // main scenarios
    c_pass: cover property (|down_clk_ch_oe);
    c_irq: cover property ($fell(irq_out_n));
    c_answer: cover property ($rose(up_dat_oe));
endmodule : ifcm_mux_monitor
bind ifcm_mux_top ifcm_mux_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .up_clk(up_clk), .up_clk_out(up_clk_out),
    .up_dat_in(up_dat_in), .up_dat_out(up_dat_out), .up_dat_oe(up_dat_oe), .down_clk_ch_out(down_clk_ch_out),
    .down_clk_ch_oe(down_clk_ch_oe), .down_dat_ch_in(down_dat_ch_in), .down_dat_ch_out(down_dat_ch_out),
    .down_dat_ch_oe(down_dat_ch_oe), .chan_irq_in_n(chan_irq_in_n), .irq_out_n(irq_out_n));
`default_nettype wire

// file: verif/ifcm_up_master.sv
// upstream bus master model driving the link clock and data
`default_nettype none
module ifcm_up_master (
    // timing reference
    input wire logic sys_clk,
    // data level in, pulls out (1 pulls low)
    input wire logic dat_lvl,
    output logic clk_pull,
    output logic dat_pull
);
    timeunit 1ns;
    timeprecision 1ns;
    int half = 13;
    // lines released, clock stands still
    initial begin
        clk_pull = 1'b0;
        dat_pull = 1'b0;
    end
    // step off the system edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask : tick
    // start, also a repeated start
    task automatic start();
        dat_pull = 1'b0;
        tick(half);
        clk_pull = 1'b0;
        tick(half);
        dat_pull = 1'b1;
        tick(half);
        clk_pull = 1'b1;
        tick(half);
    endtask : start
    task automatic stop();
        dat_pull = 1'b1;
        tick(half);
        clk_pull = 1'b0;
        tick(half);
        dat_pull = 1'b0;
        tick(half);
    endtask : stop
    // nine bits msb first, level read late in the high phase
    task automatic xfer(input logic [8:0] b, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            dat_pull = !b[i];
            tick(half);
            clk_pull = 1'b0;
            tick(half);
            r[i] = dat_lvl;
            clk_pull = 1'b1;
            tick(half);
        end
    endtask : xfer
endmodule : ifcm_up_master
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the four-channel serial multiplexer
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] irq_n = 4'hF;
    logic [3:0] dn_pull = 4'h0;
    logic [3:0] dc_pull = 4'h0;
    logic [2:0] strap = 3'h5;
    logic m_clk, m_dat, up_clk_oe, up_dat_oe, irq_out_n;
    logic clk_o, dat_o;
    logic [3:0] dc_oe, dd_oe, dc_o, dd_o;
    int n_mismatch = 0;
    int samples_checked = 0;
    // target address follows the straps
    wire logic [6:0] dev_addr = {ifcm_pkg::ADDR_HI_DEF, strap};
    // open-drain wires with pull-ups, a driven pin shows its output value
    wire logic up_clk = !m_clk && (!up_clk_oe || clk_o);
    wire logic up_dat = !m_dat && (!up_dat_oe || dat_o);
    wire logic [3:0] dc_in = (~dc_oe | dc_o) & ~dc_pull;
    wire logic [3:0] dd_in = (~dd_oe | dd_o) & ~dn_pull;
    // system clock
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    ifcm_up_master u_master (.sys_clk(sys_clk), .dat_lvl(up_dat), .clk_pull(m_clk), .dat_pull(m_dat));
    ifcm_mux_top u_dut (.sys_clk(sys_clk), .rst(rst), .up_clk(up_clk), .up_clk_out(clk_o),
        .up_clk_oe(up_clk_oe), .up_dat_in(up_dat), .up_dat_out(dat_o), .up_dat_oe(up_dat_oe),
        .down_clk_ch_in(dc_in), .down_clk_ch_out(dc_o), .down_clk_ch_oe(dc_oe),
        .down_dat_ch_in(dd_in), .down_dat_ch_out(dd_o), .down_dat_ch_oe(dd_oe),
        .chan_irq_in_n(irq_n), .irq_out_n(irq_out_n), .addr_strap(strap));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    task automatic wr_ctl(input logic [6:0] dev, input logic [7:0] data, input logic ack);
        logic [8:0] r;
        u_master.start();
        u_master.xfer({dev, 2'b01}, r);
        check({7'h0, r[0]}, {7'h0, !ack});
        if (ack) begin
            u_master.xfer({data, 1'b1}, r);
            check({7'h0, r[0]}, 8'h00);
        end
        u_master.stop();
    endtask : wr_ctl
    task automatic rd_ctl(input logic [7:0] exp, input logic [3:0] mask);
        logic [8:0] r;
        u_master.start();
        check({dc_oe, dd_oe}, {mask, mask});
        u_master.xfer({dev_addr, 2'b11}, r);
        u_master.xfer(9'h1FF, r);
        check(r[8:1], exp);
        u_master.stop();
    endtask : rd_ctl
    task automatic t_reset();
        check({dc_oe, dd_oe}, 8'h00);
        check({7'h0, irq_out_n}, 8'h01);
        rd_ctl(8'h00, 4'h0);
    endtask : t_reset
    task automatic t_bad_addr();
        wr_ctl(dev_addr ^ 7'h01, 8'h04, 1'b0);
        rd_ctl(8'h00, 4'h0);
    endtask : t_bad_addr
    task automatic t_select();
        for (int ch = 0; ch < 4; ch++) begin
            wr_ctl(dev_addr, 8'h04 | 8'(ch), 1'b1);
            rd_ctl(8'h04 | 8'(ch), 4'h1 << ch);
            dn_pull = 4'h1 << ch;
            dc_pull = 4'h1 << ch;
            u_master.tick(6);
            check({6'h0, up_clk_oe, up_dat_oe}, 8'h03);
            dn_pull = 4'h0;
            dc_pull = 4'h0;
            u_master.tick(8);
            dn_pull = 4'h1 << ((ch + 1) % 4);
            dc_pull = 4'h1 << ((ch + 1) % 4);
            u_master.tick(6);
            check({6'h0, up_clk_oe, up_dat_oe}, 8'h00);
            dn_pull = 4'h0;
            dc_pull = 4'h0;
            u_master.tick(8);
        end
        wr_ctl(dev_addr, 8'h00, 1'b1);
        rd_ctl(8'h00, 4'h0);
    endtask : t_select
    task automatic t_irq();
        u_master.half = 25;
        wr_ctl(dev_addr, 8'h06, 1'b1);
        for (int i = 0; i < 4; i++) begin
            irq_n = ~(4'h1 << i);
            u_master.tick(4);
            check({7'h0, irq_out_n}, 8'h00);
            rd_ctl({4'h1 << i, 4'h6}, 4'h4);
        end
        irq_n = 4'hF;
        u_master.tick(4);
        check({7'h0, irq_out_n}, 8'h01);
        u_master.half = 13;
    endtask : t_irq
    task automatic t_mid_reset();
        rst = 1'b1;
        strap = 3'h2;
        u_master.tick(3);
        check({dc_oe, dd_oe}, 8'h00);
        rst = 1'b0;
        u_master.tick(3);
        rd_ctl(8'h00, 4'h0);
        // straps taken in reset move the address
        wr_ctl({ifcm_pkg::ADDR_HI_DEF, 3'h5}, 8'h04, 1'b0);
        wr_ctl(dev_addr, 8'h05, 1'b1);
        rd_ctl(8'h05, 4'h2);
    endtask : t_mid_reset
    // main sequence
    initial begin
        u_master.tick(3);
        rst = 1'b0;
        u_master.tick(3);
        t_reset();
        t_bad_addr();
        t_select();
        t_irq();
        t_mid_reset();
        summarize();
    end
    // watchdog
    initial begin
        repeat (40000) @(posedge sys_clk);
        n_mismatch++;
        summarize();
    end
endmodule : tb_top
`default_nettype wire
